// [logic/charge_seq_pkg.sv]
package charge_seq_pkg;
   typedef enum logic [2:0] {
      st_idle   = 3'h0,
      st_cc     = 3'h1,
      st_cv     = 3'h3,
      st_topoff = 3'h2,
      st_done   = 3'h6,
      st_tfault = 3'h7,
      st_wdsusp = 3'h5,
      st_thermal_shutdown_limit  = 3'h4
   } charge_state_type;
   typedef struct packed {
      logic       full_shut;
      logic       wd_en;
      logic [3:0] mode;
   } charge_cfg_type;
   typedef struct packed {
      logic [7:0] to_limit;
      logic [7:0] fc_limit;
   } timer_cfg_type;
   typedef struct packed {
      logic tj_over;
      logic chgin_valid;
      logic ichg_low;
      logic vbatt_low;
      logic vbatt_at_reg;
   } sense_type;
endpackage

// [logic/charge_seq_regs.svh]
`ifndef CHARGE_SEQ_REGS_SVH
`define CHARGE_SEQ_REGS_SVH
// Notes on behaviour
// - CV reports ok, code 0x02 after debounce
// - CV to top-off after low current debounce
// - CV over fast-charge limit gives timer fault
// - soft watchdog expiry suspends any charging state
// - top-off only from CV, reports code 0x03
// - top-off duration elapsed moves to done
// - low battery in top-off/done restarts CC
// - done reports code 0x04, ok cleared
// - done gives zero current, recharge from done has no soft-start
// - fast-charge and top-off time limits
// - timer fault: immediate irq, code 0x06
// - mode or input toggle leaves timer fault
// - watchdog disabled after reset
// - soft expiry: suspend, clear write restarts
// - full expiry: all off 150ms, restart
// - overtemperature forces thermal shutdown, code 0x0A
// - thermal shutdown resets mode and O-type registers
// - interrupt source debounce times per source
// - mode 0x05 means buck plus charging
// - CC reports code 0x01 after debounce

// ====================================================
// timing
`define CLK_PERIOD_NS   10
`define SRD_TIME_US     1000
`define TERM_TIME_US    1000
`define SHDN_TIME_MS    150
`define TICK_TIME_MS    1000
`define PQ_TIME_TICKS   8'h1E
`define WD_PERIOD_TICKS 8'h50
`define DB30_TIME_US    30000
`define DB20_TIME_US    20000
`define DB7P5_TIME_NS   7500000
`define DB0P5_TIME_NS   500000
// ====================================================
// register map and reset values
`define ADR_CFG         8'h00
`define ADR_TIMERS      8'h04
`define ADR_WDCLR       8'h08
`define ADR_STATUS      8'h0C
`define ADR_EVENTS      8'h10
`define CFG_RESET       6'h05
`define MODE_DEFAULT    4'h5
`define MODE_CHG_ON     4'h5
`define TIMERS_RESET    16'h1E3C
`define WDCLR_KEY       8'h01
// ====================================================
// detail codes
`define DTL_CC          4'h1
`define DTL_CV          4'h2
`define DTL_TOPOFF      4'h3
`define DTL_DONE        4'h4
`define DTL_TFAULT      4'h6
`define DTL_OFF         4'h8
`define DTL_THERMAL_SHUTDOWN_LIMIT       4'hA
`define DTL_WDSUSP      4'hB
`endif

// [logic/charge_state_sequencer.sv]
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "charge_seq_regs.svh"
module charge_state_sequencer #(
   parameter int unsigned SRD_C  = `SRD_TIME_US*1000/`CLK_PERIOD_NS,
   parameter int unsigned TERM_C = `TERM_TIME_US*1000/`CLK_PERIOD_NS,
   parameter int unsigned SHDN_C = `SHDN_TIME_MS*100000,
   parameter int unsigned TICK_C = `TICK_TIME_MS*100000,
   parameter int unsigned DB30_C = `DB30_TIME_US*1000/`CLK_PERIOD_NS,
   // shorter debounces follow the 30 ms count, so one override scales all
   parameter int unsigned DB20_C = DB30_C*(`DB20_TIME_US/1000)
                                   /(`DB30_TIME_US/1000),
   parameter int unsigned DB7_C  = DB30_C*(`DB7P5_TIME_NS/100000)
                                   /(`DB30_TIME_US/100),
   parameter int unsigned DB0_C  = DB30_C*(`DB0P5_TIME_NS/100000)
                                   /(`DB30_TIME_US/100)
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // analog comparators, asynchronous
   input  wire logic        vbatt_at_reg_i,
   input  wire logic        vbatt_low_i,
   input  wire logic        ichg_low_i,
   input  wire logic        chgin_valid_i,
   input  wire logic        tj_over_i,
   input  wire logic [6:0]  irq_raw_i,
   // power stage control
   output logic             charge_en_o,
   output logic             soft_start_en_o,
   output logic             buck_en_o,
   output logic             batt_switch_en_o,
   // charger status
   output logic             charger_ok_flag_o,
   output logic [3:0]       charger_detail_code_o,
   output logic             charger_event_irq_o
);
   localparam logic [23:0] SRD_W  = 24'(SRD_C);
   localparam logic [23:0] TERM_W = 24'(TERM_C);
   localparam logic [23:0] SHDN_W = 24'(SHDN_C);
   localparam logic [31:0] TICK_W = 32'(TICK_C);
   localparam int unsigned RISE_C [7] =
      '{DB30_C, DB7_C, DB30_C, DB7_C, DB20_C, DB30_C, DB0_C};
   localparam int unsigned FALL_C [7] = '{DB30_C, 0, DB30_C, 0, 0, 0, 0};

   function automatic logic [23:0] sat_inc(input logic [23:0] c,
                                           input logic [23:0] lim);
      sat_inc = (c >= lim) ? c : c + 24'h1;
   endfunction

   // ====================================================
   // input synchronisers
   logic [11:0] sync1_r;
   logic [11:0] sync2_r;
   charge_seq_pkg::sense_type sense;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 12'h000;
         sync2_r <= 12'h000;
      end else begin
         sync1_r <= {irq_raw_i, tj_over_i, chgin_valid_i, ichg_low_i,
                     vbatt_low_i, vbatt_at_reg_i};
         sync2_r <= sync1_r;
      end
   end
   assign sense = charge_seq_pkg::sense_type'(sync2_r[4:0]);

   // ====================================================
   // declarations
   charge_seq_pkg::charge_state_type state_r;
   charge_seq_pkg::charge_state_type state_nxt;
   charge_seq_pkg::charge_cfg_type   cfg_r;
   charge_seq_pkg::timer_cfg_type    tmr_r;
   logic        sys_rst;
   logic        restart_r;
   logic        shut_r;
   logic [23:0] shut_cnt_r;
   logic        ack_r;
   logic [31:0] dat_r;
   logic        req;
   logic        wr;
   logic        wd_clr;
   logic [7:0]  events_r;
   logic [6:0]  db_lvl;
   logic [6:0]  db_evt;
   logic [31:0] tick_cnt_r;
   logic        tick;
   logic [7:0]  wd_cnt_r;
   logic        wd_exp;
   logic        wd_susp;
   logic [23:0] term_cnt_r;
   logic [8:0]  fc_cnt_r;
   logic [8:0]  to_cnt_r;
   logic        fc_over;
   logic        to_done;
   logic        chg_on;
   logic        rearm_r;
   logic [23:0] srd_cnt_r;
   logic        state_chg;
   logic        rep_due;
   logic        ok_r;
   logic [3:0]  detail_r;
   logic        irq_r;
   logic        chg_en_r;
   logic        soft_r;
   logic        buck_r;

   // full shutdown restart acts like power-up
   assign sys_rst = rst_i | restart_r;

   // ====================================================
   // wishbone slave
   assign req = cyc_i & stb_i;
   // write lands on the edge where the master sees ack
   assign wr  = req & we_i & ack_r;
   assign wd_clr = wr && adr_i == `ADR_WDCLR && sel_i[0] &&
                   dat_i[7:0] == `WDCLR_KEY;

   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         dat_r <= 32'h0;
      end else if (req & ~ack_r) begin
         unique case (adr_i)
            `ADR_CFG:    dat_r <= {26'h0, cfg_r};
            `ADR_TIMERS: dat_r <= {16'h0, tmr_r};
            `ADR_STATUS: dat_r <= {17'h0, db_lvl, state_r, ok_r, detail_r};
            `ADR_EVENTS: dat_r <= {24'h0, events_r};
            default:     dat_r <= 32'h0;
         endcase
      end
   end
   assign dat_o = dat_r;
   assign ack_o = ack_r;

   // ====================================================
   // configuration registers
   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         cfg_r <= `CFG_RESET;
      end else if (state_r == charge_seq_pkg::st_thermal_shutdown_limit) begin
         cfg_r.mode <= `MODE_DEFAULT;
      end else if (wr && adr_i == `ADR_CFG && sel_i[0]) begin
         cfg_r <= dat_i[5:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst || state_r == charge_seq_pkg::st_thermal_shutdown_limit) begin
         tmr_r <= `TIMERS_RESET;
      end else if (wr && adr_i == `ADR_TIMERS) begin
         if (sel_i[0]) tmr_r.fc_limit <= dat_i[7:0];
         if (sel_i[1]) tmr_r.to_limit <= dat_i[15:8];
      end
   end

   // sticky event bits, write one to clear; a new event beats the clear
   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         events_r <= 8'h00;
      end else begin
         events_r <= (events_r & ~((wr && adr_i == `ADR_EVENTS &&
                      sel_i[0]) ? dat_i[7:0] : 8'h00)) | {db_evt, irq_r};
      end
   end

   // ====================================================
   // interrupt source debounce
   for (genvar g = 0; g < 7; g++) begin : g_db
      event_debounce #(
         .RISE_C (RISE_C[g]),
         .FALL_C (FALL_C[g])
      ) u_db (
         .clk_i   (clk_i),
         .rst_i   (sys_rst),
         .level_i (sync2_r[5+g]),
         .level_o (db_lvl[g]),
         .event_o (db_evt[g])
      );
   end

   // ====================================================
   // timebase, watchdog and full shutdown
   assign tick = tick_cnt_r == TICK_W - 32'h1;

   always_ff @(posedge clk_i) begin
      if (sys_rst || tick) tick_cnt_r <= 32'h0;
      else tick_cnt_r <= tick_cnt_r + 32'h1;
   end

   // counting stops once expired, so expiry holds until cleared
   always_ff @(posedge clk_i) begin
      if (sys_rst || !cfg_r.wd_en || wd_clr) begin
         wd_cnt_r <= 8'h00;
      end else if (tick && !wd_exp) begin
         wd_cnt_r <= wd_cnt_r + 8'h01;
      end
   end
   assign wd_exp  = cfg_r.wd_en && wd_cnt_r >= `WD_PERIOD_TICKS;
   assign wd_susp = wd_exp & ~cfg_r.full_shut;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shut_r     <= 1'b0;
         shut_cnt_r <= 24'h0;
         restart_r  <= 1'b0;
      end else begin
         restart_r <= shut_r && shut_cnt_r == SHDN_W - 24'h1;
         if (restart_r) begin
            shut_r <= 1'b0;
         end else if (wd_exp && cfg_r.full_shut && !shut_r) begin
            shut_r     <= 1'b1;
            shut_cnt_r <= 24'h0;
         end else if (shut_r) begin
            shut_cnt_r <= sat_inc(shut_cnt_r, SHDN_W);
         end
      end
   end

   // ====================================================
   // charge timers
   always_ff @(posedge clk_i) begin
      if (sys_rst || !(state_r inside {charge_seq_pkg::st_cv})
                  || !sense.ichg_low) begin
         term_cnt_r <= 24'h0;
      end else begin
         term_cnt_r <= sat_inc(term_cnt_r, TERM_W);
      end
   end

   // one budget spans CC and CV together
   always_ff @(posedge clk_i) begin
      if (sys_rst || !(state_r inside {charge_seq_pkg::st_cc,
                                       charge_seq_pkg::st_cv})) begin
         fc_cnt_r <= 9'h000;
      end else if (tick && fc_cnt_r != 9'h1FF) begin
         fc_cnt_r <= fc_cnt_r + 9'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst || state_r != charge_seq_pkg::st_topoff) begin
         to_cnt_r <= 9'h000;
      end else if (tick && to_cnt_r != 9'h1FF) begin
         to_cnt_r <= to_cnt_r + 9'h001;
      end
   end
   assign fc_over = fc_cnt_r > {1'b0, tmr_r.fc_limit};
   assign to_done = to_cnt_r >= {1'b0, tmr_r.to_limit};
   assign chg_on  = cfg_r.mode == `MODE_CHG_ON && sense.chgin_valid;

   // fault returns to idle only after the charger was seen off once
   always_ff @(posedge clk_i) begin
      if (sys_rst || state_r != charge_seq_pkg::st_tfault) rearm_r <= 1'b0;
      else if (!chg_on) rearm_r <= 1'b1;
   end

   // ====================================================
   // state machine
   always_comb begin
      state_nxt = state_r;
      if (sense.tj_over) begin
         state_nxt = charge_seq_pkg::st_thermal_shutdown_limit;
      end else begin
         unique case (state_r)
            charge_seq_pkg::st_idle:
               if (chg_on) state_nxt = charge_seq_pkg::st_cc;
            charge_seq_pkg::st_cc:
               if (wd_susp) state_nxt = charge_seq_pkg::st_wdsusp;
               else if (!chg_on) state_nxt = charge_seq_pkg::st_idle;
               else if (fc_over) state_nxt = charge_seq_pkg::st_tfault;
               else if (sense.vbatt_at_reg)
                  state_nxt = charge_seq_pkg::st_cv;
            charge_seq_pkg::st_cv:
               if (wd_susp) state_nxt = charge_seq_pkg::st_wdsusp;
               else if (!chg_on) state_nxt = charge_seq_pkg::st_idle;
               else if (fc_over)
                  state_nxt = charge_seq_pkg::st_tfault;
               else if (term_cnt_r >= TERM_W)
                  state_nxt = charge_seq_pkg::st_topoff;
            charge_seq_pkg::st_topoff:
               if (wd_susp) state_nxt = charge_seq_pkg::st_wdsusp;
               else if (!chg_on) state_nxt = charge_seq_pkg::st_idle;
               else if (sense.vbatt_low)
                  state_nxt = charge_seq_pkg::st_cc;
               else if (to_done)
                  state_nxt = charge_seq_pkg::st_done;
            charge_seq_pkg::st_done:
               if (wd_susp) state_nxt = charge_seq_pkg::st_wdsusp;
               else if (!chg_on) state_nxt = charge_seq_pkg::st_idle;
               else if (sense.vbatt_low)
                  state_nxt = charge_seq_pkg::st_cc;
            charge_seq_pkg::st_tfault:
               if (wd_susp) state_nxt = charge_seq_pkg::st_wdsusp;
               else if (rearm_r && chg_on)
                  state_nxt = charge_seq_pkg::st_idle;
            charge_seq_pkg::st_wdsusp:
               if (!wd_exp) state_nxt = charge_seq_pkg::st_idle;
            charge_seq_pkg::st_thermal_shutdown_limit:
               state_nxt = charge_seq_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst) state_r <= charge_seq_pkg::st_idle;
      else state_r <= state_nxt;
   end

   // ====================================================
   // status reporting
   assign state_chg = state_nxt != state_r;
   assign rep_due   = !state_chg && srd_cnt_r == SRD_W - 24'h1;

   always_ff @(posedge clk_i) begin
      if (sys_rst || state_chg) srd_cnt_r <= 24'h0;
      else srd_cnt_r <= sat_inc(srd_cnt_r, SRD_W);
   end

   // fault states and idle report at entry, others once the state has settled
   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         ok_r     <= 1'b0;
         detail_r <= `DTL_OFF;
         irq_r    <= 1'b0;
      end else if (state_chg) begin
         irq_r <= 1'b0;
         if (state_nxt == charge_seq_pkg::st_tfault) begin
            irq_r    <= 1'b1;
            ok_r     <= 1'b0;
            detail_r <= `DTL_TFAULT;
         end else if (state_nxt == charge_seq_pkg::st_wdsusp) begin
            irq_r    <= ok_r;
            ok_r     <= 1'b0;
            detail_r <= `DTL_WDSUSP;
         end else if (state_nxt == charge_seq_pkg::st_thermal_shutdown_limit) begin
            irq_r    <= ok_r;
            ok_r     <= 1'b0;
            detail_r <= `DTL_THERMAL_SHUTDOWN_LIMIT;
         end else if (state_nxt == charge_seq_pkg::st_idle) begin
            detail_r <= `DTL_OFF;
         end
      end else if (rep_due && state_r inside {charge_seq_pkg::st_cc,
                   charge_seq_pkg::st_cv, charge_seq_pkg::st_topoff}) begin
         irq_r <= ~ok_r;
         ok_r  <= 1'b1;
         if (state_r == charge_seq_pkg::st_cc)
            detail_r <= `DTL_CC;
         else if (state_r == charge_seq_pkg::st_cv)
            detail_r <= `DTL_CV;
         else
            detail_r <= `DTL_TOPOFF;
      end else if (rep_due && state_r == charge_seq_pkg::st_done) begin
         irq_r    <= ~ok_r;
         ok_r     <= 1'b0;
         detail_r <= `DTL_DONE;
      end else begin
         irq_r <= 1'b0;
      end
   end
   assign charger_ok_flag_o     = ok_r;
   assign charger_detail_code_o = detail_r;
   assign charger_event_irq_o   = irq_r;

   // ====================================================
   // power stage outputs
   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         chg_en_r <= 1'b0;
         soft_r   <= 1'b0;
         buck_r   <= 1'b0;
      end else begin
         chg_en_r <= !shut_r && !(wd_exp && cfg_r.full_shut) &&
                     state_nxt inside {charge_seq_pkg::st_cc,
                     charge_seq_pkg::st_cv, charge_seq_pkg::st_topoff};
         if (state_chg && state_nxt == charge_seq_pkg::st_cc)
            soft_r <= state_r == charge_seq_pkg::st_idle;
         buck_r <= !shut_r && !(wd_exp && cfg_r.full_shut);
      end
   end
   assign charge_en_o      = chg_en_r;
   assign soft_start_en_o  = soft_r;
   assign buck_en_o        = buck_r;
   assign batt_switch_en_o = buck_r;

   // ====================================================
   // checks
   a_cv_report: assert property (@(posedge clk_i) disable iff (sys_rst)
      rep_due && state_r == charge_seq_pkg::st_cv |=>
         ok_r && detail_r == `DTL_CV && irq_r == !$past(ok_r))
      else $error("cv status wrong");
   a_topoff_entry: assert property (@(posedge clk_i) disable iff (sys_rst)
      state_r == charge_seq_pkg::st_topoff && $changed(state_r) |->
         $past(state_r) == charge_seq_pkg::st_cv)
      else $error("top-off entered from wrong state");
   a_fault_report: assert property (@(posedge clk_i) disable iff (sys_rst)
      state_r == charge_seq_pkg::st_tfault && $changed(state_r) |->
         irq_r && !ok_r && detail_r == `DTL_TFAULT)
      else $error("timer fault status wrong");
   a_done_no_current: assert property (@(posedge clk_i) disable iff (sys_rst)
      state_r == charge_seq_pkg::st_done |-> !charge_en_o)
      else $error("current in done");
   a_done_report: assert property (@(posedge clk_i) disable iff (sys_rst)
      rep_due && state_r == charge_seq_pkg::st_done |=>
         !ok_r && detail_r == `DTL_DONE)
      else $error("done status wrong");
   a_wd_reset_off: assert property (@(posedge clk_i)
      $past(rst_i) |-> !cfg_r.wd_en)
      else $error("watchdog enabled after reset");
   a_wd_suspend: assert property (@(posedge clk_i) disable iff (sys_rst)
      wd_susp && !sense.tj_over && state_r inside {charge_seq_pkg::st_cc,
         charge_seq_pkg::st_cv, charge_seq_pkg::st_topoff,
         charge_seq_pkg::st_done} |=>
         state_r == charge_seq_pkg::st_wdsusp ##1 !charge_en_o)
      else $error("watchdog expiry ignored");
   a_thermal_entry: assert property (@(posedge clk_i) disable iff (sys_rst)
      sense.tj_over |=> state_r == charge_seq_pkg::st_thermal_shutdown_limit ##1
         cfg_r.mode == `MODE_DEFAULT)
      else $error("thermal shutdown missed");
   a_full_shut_off: assert property (@(posedge clk_i) disable iff (rst_i)
      shut_r |=> !buck_en_o && !batt_switch_en_o && !charge_en_o)
      else $error("power on during shutdown");
   a_status_hold: assert property (@(posedge clk_i) disable iff (sys_rst)
      state_chg && state_nxt == charge_seq_pkg::st_cv |=> $stable(ok_r))
      else $error("status changed before debounce");

   c_cv_topoff: cover property (@(posedge clk_i)
      state_r == charge_seq_pkg::st_cv ##1
      state_r == charge_seq_pkg::st_topoff);
   c_done_recharge: cover property (@(posedge clk_i)
      state_r == charge_seq_pkg::st_done ##1 state_r == charge_seq_pkg::st_cc);
   c_timer_fault: cover property (@(posedge clk_i)
      state_r == charge_seq_pkg::st_tfault);
   c_wd_suspend: cover property (@(posedge clk_i)
      state_r == charge_seq_pkg::st_wdsusp);
endmodule
`default_nettype wire

// [logic/event_debounce.sv]
`timescale 1ns/10ps
`default_nettype none
module event_debounce #(
   parameter int unsigned RISE_C = 1,
   parameter int unsigned FALL_C = 0
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // filtered source
   input  wire logic level_i,
   output logic      level_o,
   output logic      event_o
);
   localparam logic [23:0] RISE_W = 24'(RISE_C);
   localparam logic [23:0] FALL_W = 24'(FALL_C);
   logic [23:0] cnt_r;
   logic [23:0] need;

   // a zero count passes that edge through at once
   assign need = level_i ? RISE_W : FALL_W;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r   <= 24'h0;
         level_o <= 1'b0;
         event_o <= 1'b0;
      end else if (level_i == level_o) begin
         cnt_r   <= 24'h0;
         event_o <= 1'b0;
      end else if (cnt_r + 24'h1 >= need) begin
         cnt_r   <= 24'h0;
         level_o <= level_i;
         event_o <= 1'b1;
      end else begin
         cnt_r   <= cnt_r + 24'h1;
         event_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [tb/charge_state_sequencer_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module charge_state_sequencer_tb;
   // ==========
   // stimulus and observed signals
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic        ack_o;
   logic        vreg = 1'b0, vlow = 1'b0, ilow = 1'b0, vin = 1'b0, tj = 1'b0;
   logic [6:0]  raw = 7'h00;
   logic        chg_en, soft_en, buck_en, bsw_en, ok, irq;
   logic [3:0]  code;
   int          fails = 0, n_checks = 0, k;

   // short counts keep the run small; waits below are sized from them
   charge_state_sequencer #(.SRD_C(8), .TERM_C(4), .SHDN_C(20), .TICK_C(10),
      .DB30_C(60)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .vbatt_at_reg_i(vreg),
      .vbatt_low_i(vlow), .ichg_low_i(ilow), .chgin_valid_i(vin),
      .tj_over_i(tj), .irq_raw_i(raw), .charge_en_o(chg_en),
      .soft_start_en_o(soft_en), .buck_en_o(buck_en),
      .batt_switch_en_o(bsw_en), .charger_ok_flag_o(ok),
      .charger_detail_code_o(code), .charger_event_irq_o(irq));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // ==========
   // checking and bus tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task summarize;
      if (fails == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // classic cycle: hold everything until ack is sampled high
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      if (i == 20) begin
         fails++;
         summarize();
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   // sample just after the edge so the report and its pulse have landed
   task wt(input logic [3:0] c, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge clk_i);
         #1;
         if (code === c) break;
      end
      chk(code, c);
      if (i == lim) summarize();
   endtask

   // ==========
   // main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h05);
      wb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h1E3C);
      wb(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, 8'h04, 32'h0208);
      vin <= 1'b1;
      wt(4'h1, 40);
      chk(soft_en, 1'b1);
      vreg <= 1'b1;
      wt(4'h2, 40);
      chk(irq, 1'b0);
      ilow <= 1'b1;
      wt(4'h3, 40);
      chk(chg_en, 1'b1);
      wt(4'h4, 60);
      chk(ok, 1'b0);
      chk(chg_en, 1'b0);
      vlow <= 1'b1;
      vreg <= 1'b0;
      ilow <= 1'b0;
      wt(4'h1, 40);
      chk(irq, 1'b1);
      chk(soft_en, 1'b0);
      vlow <= 1'b0;
      vreg <= 1'b1;
      wt(4'h2, 40);
      wt(4'h6, 200);
      chk(irq, 1'b1);
      chk(chg_en, 1'b0);
      // widen the fast-charge limit so later phases cannot fault
      wb(1'b1, 8'h04, 32'h02FF);
      vreg <= 1'b0;
      wb(1'b1, 8'h00, 32'h00);
      wb(1'b1, 8'h00, 32'h05);
      wt(4'h1, 80);
      raw <= 7'h7F;
      repeat (70) @(posedge clk_i);
      wb(1'b0, 8'h0C, 32'h0);
      chk(q[14:8], 7'h7F);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'hFF);
      wb(1'b1, 8'h10, 32'hFF);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h00);
      wb(1'b1, 8'h00, 32'h04);
      wt(4'h8, 20);
      tj <= 1'b1;
      wt(4'hA, 20);
      wb(1'b0, 8'h00, 32'h0);
      chk(q[3:0], 4'h5);
      wb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h1E3C);
      tj <= 1'b0;
      wt(4'h1, 60);
      wb(1'b1, 8'h04, 32'h02FF);
      wb(1'b1, 8'h00, 32'h15);
      wt(4'hB, 1200);
      chk(irq, 1'b1);
      chk({chg_en, buck_en}, 2'b01);
      wb(1'b1, 8'h08, 32'h01);
      wt(4'h1, 80);
      wb(1'b1, 8'h00, 32'h35);
      for (k = 0; k < 1200 && buck_en !== 1'b0; k++) begin
         @(posedge clk_i);
         #1;
      end
      chk({buck_en, bsw_en, chg_en}, 3'b000);
      for (k = 0; k < 80 && buck_en !== 1'b1; k++) begin
         @(posedge clk_i);
         #1;
      end
      chk(buck_en, 1'b1);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h05);
      summarize();
   end
endmodule
`default_nettype wire
